// [inc/smzp_cfg.svh]
/*
 * Constants for the mode-write, ZQ calibration and power-down command block.
 * Assumes a 125 MHz system clock; all counts are derived from times in ns.
 */
`ifndef SMZP_CFG_SVH
`define SMZP_CFG_SVH

`define SMZP_CLK_NS        8
`define SMZP_TMRW_NS       40
`define SMZP_TMRW_CYC      ((`SMZP_TMRW_NS + `SMZP_CLK_NS - 1) / `SMZP_CLK_NS)
`define SMZP_TINIT4_NS     1000
`define SMZP_TINIT4_CYC    ((`SMZP_TINIT4_NS + `SMZP_CLK_NS - 1) / `SMZP_CLK_NS)
`define SMZP_TZQINIT_NS    1000
`define SMZP_TZQINIT_CYC   ((`SMZP_TZQINIT_NS + `SMZP_CLK_NS - 1) / `SMZP_CLK_NS)
`define SMZP_TZQCL_NS      360
`define SMZP_TZQCL_CYC     ((`SMZP_TZQCL_NS + `SMZP_CLK_NS - 1) / `SMZP_CLK_NS)
`define SMZP_TZQCS_NS      90
`define SMZP_TZQCS_CYC     ((`SMZP_TZQCS_NS + `SMZP_CLK_NS - 1) / `SMZP_CLK_NS)
`define SMZP_TZQRST_NS     50
`define SMZP_TZQRST_CYC    ((`SMZP_TZQRST_NS + `SMZP_CLK_NS - 1) / `SMZP_CLK_NS)
`define SMZP_CNT_W         16

`define SMZP_MA_ZQ         8'h0a
`define SMZP_MA_RESET      8'h3f
`define SMZP_OP_ZQINIT     8'hff
`define SMZP_OP_ZQCS       8'hab
`define SMZP_OP_ZQCL       8'h56
`define SMZP_OP_ZQRESET    8'hc3
`define SMZP_OP_ZQLONG     8'h56
`define SMZP_MR_RESET_VAL  8'h00
`define SMZP_RO_LO         8'h00
`define SMZP_RO_HI         8'h08

`endif

// [inc/smzp_pkg.sv]
/*
 * Types for the mode-write, ZQ calibration and power-down command block.
 * Assumes smzp_cfg.svh provides the numeric constants.
 */
package smzp_pkg;

    typedef enum logic [2:0] {
        ZQ_NONE,
        ZQ_INIT,
        ZQ_LONG,
        ZQ_SHORT,
        ZQ_RESET
    } smzp_zq_op_t;

    typedef struct packed {
        logic       valid;
        logic       is_reset;
        logic [7:0] addr;
        logic [7:0] data;
    } smzp_mrw_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic       we;
    } smzp_mr_wr_t;

endpackage

// [design/smzp_mr_mem.sv]
/*
 * Mode register array: 256 entries of 8 bits, registered read data.
 * Assumes writes arrive as single-cycle strobes; clear restores defaults.
 */
`timescale 1ns/1ns
`include "smzp_cfg.svh"

module smzp_mr_mem #(
    parameter int DEPTH = 256
) (
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    input  wire smzp_pkg::smzp_mr_wr_t wr,
    input  wire logic                clear,
    input  wire logic [7:0]          rd_addr,
    output logic      [7:0]          rd_data
);
    logic [7:0] mem_q [DEPTH];

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_ent
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_q[gi] <= `SMZP_MR_RESET_VAL;
                end else if (clear) begin
                    mem_q[gi] <= `SMZP_MR_RESET_VAL;
                end else if (wr.we && wr.addr == 8'(gi)) begin
                    mem_q[gi] <= wr.data;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= `SMZP_MR_RESET_VAL;
        end else begin
            rd_data <= mem_q[rd_addr];
        end
    end
endmodule

// [design/smzp_top.sv]
/*
 * Device-side command handling for mode register write (and its reset
 * form), ZQ calibration and synchronous power-down.
 * Assumes cs_n, cke and the two CA halves are synchronous to sys_clk: ca_r
 * holds the rising-edge half and ca_f the falling-edge half of one command.
 */
// How it works
// - MRW decoded from CS low, CA3..CA0 low.
// - Address and data taken from CA halves.
// - Writes to read-only registers are dropped.
// - Idle, writing state, then back to idle.
// - Reset MRW enters auto-init, restores defaults.
// - Only NOP during init; array holds defaults after.
// - Four ZQ operations via register 0Ah.
// - ZQ tied to supply: ignore calibration.
// - Calibration pin circuitry off when done.
// - Short calibration fits its period.
// - CKE low with CS high enters power-down.
// - Idle or active power-down by open rows.
// - Power-down disables buffers, ignores inputs.
// - No refresh performed while powered down.
`timescale 1ns/1ns
`include "smzp_cfg.svh"

module smzp_top #(
    parameter int INIT_CYC = `SMZP_TINIT4_CYC,
    parameter int MRW_CYC  = `SMZP_TMRW_CYC
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       cs_n,
    input  wire logic       cke,
    input  wire logic [9:0] ca_r,
    input  wire logic [9:0] ca_f,
    input  wire logic       banks_idle,
    input  wire logic       zq_tied_high,
    input  wire logic [7:0] mr_rd_addr,
    output logic      [7:0] mr_rd_data,
    output logic            zq_pin_en,
    output logic            zq_busy,
    output logic            in_buf_en,
    output logic            refresh_allow,
    output logic            pd_idle,
    output logic            pd_active,
    output logic            dev_idle,
    output logic            init_busy
);
    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WRITING,
        ST_INIT,
        ST_ZQ,
        ST_PD
    } smzp_state_t;

    smzp_state_t          st_q;
    logic [`SMZP_CNT_W-1:0] cnt_q;
    logic                 pd_act_q;
    smzp_pkg::smzp_mrw_t  mrw;
    smzp_pkg::smzp_mr_wr_t wr;
    smzp_pkg::smzp_zq_op_t zq_op;
    logic                 read_only;
    logic                 pd_enter;

    always_comb begin
        mrw.valid    = cke && !cs_n && ca_r[3:0] == 4'h0;
        mrw.addr     = {ca_r[9:4], ca_f[1:0]};
        mrw.data     = ca_f[9:2];
        mrw.is_reset = mrw.addr == `SMZP_MA_RESET;
    end

    assign read_only = mrw.addr >= `SMZP_RO_LO && mrw.addr <= `SMZP_RO_HI
                       && mrw.addr != `SMZP_MA_ZQ;

    always_comb begin
        zq_op = smzp_pkg::ZQ_NONE;
        if (mrw.addr == `SMZP_MA_ZQ && !zq_tied_high) begin
            case (mrw.data)
                `SMZP_OP_ZQINIT:  zq_op = smzp_pkg::ZQ_INIT;
                `SMZP_OP_ZQRESET: zq_op = smzp_pkg::ZQ_RESET;
                `SMZP_OP_ZQCS:    zq_op = smzp_pkg::ZQ_SHORT;
                `SMZP_OP_ZQCL:    zq_op = smzp_pkg::ZQ_LONG;
                default:          zq_op = smzp_pkg::ZQ_NONE;
            endcase
        end
    end

    assign pd_enter = !cke && cs_n;

    always_comb begin
        wr.we   = st_q == ST_IDLE && mrw.valid && !mrw.is_reset && !read_only
                  && mrw.addr != `SMZP_MA_ZQ && banks_idle;
        wr.addr = mrw.addr;
        wr.data = mrw.data;
    end

    // ----------------------------------------------------------------
    // Main state machine
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q  <= ST_IDLE;
            cnt_q <= '0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (pd_enter) begin
                        st_q <= ST_PD;
                    end else if (mrw.valid && banks_idle) begin
                        if (mrw.is_reset) begin
                            st_q  <= ST_INIT;
                            cnt_q <= `SMZP_CNT_W'(INIT_CYC - 1);
                        end else if (zq_op != smzp_pkg::ZQ_NONE) begin
                            st_q <= ST_ZQ;
                            case (zq_op)
                                smzp_pkg::ZQ_INIT:  cnt_q <= `SMZP_CNT_W'(`SMZP_TZQINIT_CYC - 1);
                                smzp_pkg::ZQ_LONG:  cnt_q <= `SMZP_CNT_W'(`SMZP_TZQCL_CYC - 1);
                                smzp_pkg::ZQ_SHORT: cnt_q <= `SMZP_CNT_W'(`SMZP_TZQCS_CYC - 1);
                                default:            cnt_q <= `SMZP_CNT_W'(`SMZP_TZQRST_CYC - 1);
                            endcase
                        end else begin
                            st_q  <= ST_WRITING;
                            cnt_q <= `SMZP_CNT_W'(MRW_CYC - 1);
                        end
                    end
                end
                ST_WRITING, ST_INIT, ST_ZQ: begin
                    if (cnt_q == '0) begin
                        st_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                ST_PD: begin
                    if (cke) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_act_q <= 1'b0;
        end else if (st_q == ST_IDLE && pd_enter) begin
            pd_act_q <= !banks_idle;
        end
    end

    smzp_mr_mem #(
        .DEPTH(256)
    ) u_mem (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .wr      (wr),
        .clear   (st_q == ST_IDLE && mrw.valid && banks_idle && mrw.is_reset),
        .rd_addr (mr_rd_addr),
        .rd_data (mr_rd_data)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign zq_busy       = st_q == ST_ZQ;
    assign zq_pin_en     = st_q == ST_ZQ;
    assign in_buf_en     = st_q != ST_PD;
    assign refresh_allow = st_q != ST_PD;
    assign pd_idle       = st_q == ST_PD && !pd_act_q;
    assign pd_active     = st_q == ST_PD && pd_act_q;
    assign dev_idle      = st_q == ST_IDLE;
    assign init_busy     = st_q == ST_INIT;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Counts the cycles spent in the writing state for the period check.
    logic [`SMZP_CNT_W-1:0] wr_len_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_len_q <= '0;
        end else if (st_q == ST_WRITING) begin
            wr_len_q <= wr_len_q + 1'b1;
        end else begin
            wr_len_q <= '0;
        end
    end

    sequence s_mrw_idle;
        st_q == ST_IDLE && mrw.valid && banks_idle && !pd_enter;
    endsequence

    a_mrw_to_writing: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_mrw_idle ##0 (!mrw.is_reset && zq_op == smzp_pkg::ZQ_NONE) |=> st_q == ST_WRITING)
        else $error("mode write did not enter writing state");
    a_reset_to_init: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_mrw_idle ##0 mrw.is_reset |=> init_busy)
        else $error("reset write did not enter init");
    a_ro_no_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        read_only |-> !wr.we)
        else $error("read-only register written");
    a_zq_tied_ignore: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_q == ST_IDLE && zq_tied_high |=> !zq_busy)
        else $error("calibration started with pin tied");
    a_zq_pin_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_q == ST_ZQ && cnt_q == '0 |=> !zq_pin_en)
        else $error("calibration pin left on");
    a_pd_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_q == ST_IDLE && pd_enter |=> !in_buf_en)
        else $error("power-down not entered");
    a_pd_kind: assert property (@(posedge sys_clk) disable iff (!rst_n)
        st_q == ST_IDLE && pd_enter && !banks_idle |=> pd_active)
        else $error("active power-down misclassified");
    a_pd_no_ref: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pd_idle || pd_active |-> !refresh_allow)
        else $error("refresh allowed in power-down");
    a_write_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(st_q == ST_WRITING) |-> dev_idle && wr_len_q == `SMZP_CNT_W'(MRW_CYC))
        else $error("write period length wrong");
endmodule

// [tb/smzp_ctrl_model.sv]
/*
 * Memory controller model that drives chip select, clock enable and both CA halves.
 * Assumes the bench calls its tasks and that inputs change on the falling edge.
 */
`timescale 1ns/1ns
module smzp_ctrl_model (
    input  wire logic       sys_clk,
    output logic            cs_n,
    output logic            cke,
    output logic      [9:0] ca_r,
    output logic      [9:0] ca_f
);
    initial begin
        cs_n = 1'b1;
        cke  = 1'b1;
        ca_r = 10'h155;
        ca_f = 10'h2aa;
    end
    // Deselected cycles invert the CA bus so a stale command never looks valid.
    task automatic nop();
        @(negedge sys_clk);
        cs_n = 1'b1;
        ca_r = ~ca_r;
        ca_f = ~ca_f;
    endtask
    task automatic mrw(input logic [7:0] addr, input logic [7:0] data);
        @(negedge sys_clk);
        cs_n = 1'b0;
        ca_r = {addr[7:2], 4'h0};
        ca_f = {data, addr[1:0]};
        nop();
    endtask
    task automatic set_cke(input logic lvl);
        @(negedge sys_clk);
        cs_n = 1'b1;
        cke  = lvl;
        ca_r = ~ca_r;
    endtask
endmodule

// [tb/sdram_mode_zq_powerdown_tb_top.sv]
/*
 * Self-checking bench for the mode-write, ZQ and power-down block.
 * Assumes smzp_cfg.svh and the controller model are compiled alongside.
 */
`timescale 1ns/1ns
`include "smzp_cfg.svh"
module sdram_mode_zq_powerdown_tb_top;
    localparam int INIT_T = 4;
    localparam int MRW_T  = 2;
    logic       sys_clk, rst_n, cs_n, cke, banks_idle, zq_tied_high;
    logic [9:0] ca_r, ca_f;
    logic [7:0] mr_rd_addr, mr_rd_data, rd, n;
    logic       zq_pin_en, zq_busy, in_buf_en, refresh_allow, pd_idle, pd_active, dev_idle, init_busy;
    int         err_count, n_compared, cyc;

    smzp_ctrl_model ctrl_u (.sys_clk(sys_clk), .cs_n(cs_n), .cke(cke), .ca_r(ca_r), .ca_f(ca_f));
    smzp_top #(.INIT_CYC(INIT_T), .MRW_CYC(MRW_T)) dut_u (
        .sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .cke(cke), .ca_r(ca_r), .ca_f(ca_f),
        .banks_idle(banks_idle), .zq_tied_high(zq_tied_high), .mr_rd_addr(mr_rd_addr),
        .mr_rd_data(mr_rd_data), .zq_pin_en(zq_pin_en), .zq_busy(zq_busy), .in_buf_en(in_buf_en),
        .refresh_allow(refresh_allow), .pd_idle(pd_idle), .pd_active(pd_active),
        .dev_idle(dev_idle), .init_busy(init_busy));

    always #4 sys_clk = ~sys_clk;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic read_mr(input logic [7:0] addr);
        @(negedge sys_clk);
        mr_rd_addr = addr;
        @(negedge sys_clk);
        rd = mr_rd_data;
    endtask
    // Counts busy cycles of the chosen flag until the device is idle again.
    task automatic measure(input int sel);
        n = 8'h00;
        for (int i = 0; i < 400; i++) begin
            if (dev_idle === 1'b1) break;
            if ((sel == 0 ? !dev_idle : sel == 1 ? zq_busy : init_busy) === 1'b1) n++;
            @(negedge sys_clk);
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_mrw();
        ctrl_u.mrw(8'h10, 8'h5a);
        measure(0);
        check("mrw period", MRW_T[7:0], n);
        ctrl_u.mrw(8'h09, 8'h3c);
        measure(0);
        ctrl_u.mrw(8'h08, 8'h77);
        measure(0);
        read_mr(8'h10);
        check("mr 10", 8'h5a, rd);
        read_mr(8'h09);
        check("mr 09", 8'h3c, rd);
        read_mr(8'h08);
        check("mr 08 read-only", 8'h00, rd);
    endtask
    task automatic t_refuse();
        banks_idle = 1'b0;
        ctrl_u.mrw(8'h12, 8'h99);
        measure(0);
        check("mrw banks busy", 8'h00, n);
        read_mr(8'h12);
        check("mr 12", 8'h00, rd);
        banks_idle = 1'b1;
    endtask
    task automatic t_zq();
        logic [7:0] op [4] = '{`SMZP_OP_ZQINIT, `SMZP_OP_ZQCL, `SMZP_OP_ZQCS, `SMZP_OP_ZQRESET};
        int         len [4] = '{`SMZP_TZQINIT_CYC, `SMZP_TZQCL_CYC, `SMZP_TZQCS_CYC, `SMZP_TZQRST_CYC};
        for (int i = 0; i < 4; i++) begin
            ctrl_u.mrw(`SMZP_MA_ZQ, op[i]);
            measure(1);
            check("zq period", len[i][7:0], n);
            check("zq pin off", 8'h00, {7'h00, zq_pin_en});
        end
        zq_tied_high = 1'b1;
        ctrl_u.mrw(`SMZP_MA_ZQ, `SMZP_OP_ZQINIT);
        measure(1);
        check("zq tied", 8'h00, n);
        zq_tied_high = 1'b0;
    endtask
    task automatic t_reset();
        ctrl_u.mrw(`SMZP_MA_RESET, 8'h00);
        measure(2);
        check("init period", INIT_T[7:0], n);
        read_mr(8'h10);
        check("mr 10 default", `SMZP_MR_RESET_VAL, rd);
    endtask
    task automatic t_pd(input logic bi);
        banks_idle = bi;
        ctrl_u.set_cke(1'b0);
        ctrl_u.nop();
        ctrl_u.mrw(8'h13, 8'h44);
        check("pd kind", {6'h00, bi, ~bi}, {6'h00, pd_idle, pd_active});
        check("pd buffers", 8'h00, {6'h00, in_buf_en, refresh_allow});
        ctrl_u.set_cke(1'b1);
        banks_idle = 1'b1;
        @(negedge sys_clk);
        check("pd exit", 8'h0e, {4'h0, dev_idle, in_buf_en, refresh_allow, pd_idle | pd_active});
        read_mr(8'h13);
        check("mr 13", 8'h00, rd);
    endtask

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            tally_and_finish();
        end
    end

    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        banks_idle = 1'b1;
        zq_tied_high = 1'b0;
        mr_rd_addr = 8'h00;
        err_count = 0;
        n_compared = 0;
        cyc = 0;
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        check("reset flags", 8'h0e, {4'h0, dev_idle, in_buf_en, refresh_allow, zq_busy | init_busy});
        t_mrw();
        t_refuse();
        t_zq();
        t_reset();
        t_pd(1'b1);
        t_pd(1'b0);
        tally_and_finish();
    end
endmodule
